// *** verilog/sfci_flash_front.sv ***
/*
 * Serial flash command front end plus its program-data FIFO.
 * Assumes: pins are asynchronous to ref_clk and the serial clock is at
 * most an eighth of ref_clk; the memory back end answers a read one
 * enabled cycle after memRdReq, gathers program bytes from the FIFO into
 * its own page buffer, and pulses memOpDone once per started operation.
 */
// Operation
// RQ1: drive read data after falling clock edges
// RQ2: sample input bits on rising clock edges
// RQ3: chip select high tri-states outputs
// RQ4: ignore commands until first select fall
// RQ5: pause low freezes link, tri-states outputs
// RQ6: write protect low rejects protected writes
// RQ7: lanes act bidirectional in dual, quad
// RQ8: modes 0 and 3 both supported
// RQ9: master parks clock per mode
// RQ10: whole bytes; stopped clock tolerated
// RQ11: host sends write enable, then program
// RQ12: page program takes 1 to 256 bytes
// RQ13: programming only clears bits
// RQ14: quad page program over four lanes
// RQ15: dual/quad reads: wide address and data
// RQ16: wipes set sector or array to ones
// RQ17: small and mid parameter wipes supported
// RQ18: pending bit set while operation runs
// RQ19: program and erase failure bits
// RQ20: select low means active power
// RQ21: standby only after operations finish
// RQ22: quad bit turns protect, pause into lanes
// RQ23: opcode, address most significant bit first
// RQ24: completion clears write enable latch
`timescale 1ns/1ps

module sfci_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	input  wire logic             ref_clk,
	input  wire logic             rstn,
	input  wire logic             clkEn,
	input  wire logic             inValid,
	output logic                  inReady,
	input  wire logic [WIDTH-1:0] inData,
	output logic                  outValid,
	input  wire logic             outReady,
	output logic      [WIDTH-1:0] outData
);
	localparam int PW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];   // Storage words
	logic [PW:0]      wrPtr_q;       // Extra bit tells full from empty
	logic [PW:0]      rdPtr_q;

	assign inReady  = (wrPtr_q[PW-1:0] != rdPtr_q[PW-1:0]) || (wrPtr_q[PW] == rdPtr_q[PW]);
	assign outValid = wrPtr_q != rdPtr_q;
	assign outData  = mem[rdPtr_q[PW-1:0]];

	// Write side
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			wrPtr_q <= '0;
		end else if (clkEn && inValid && inReady) begin
			mem[wrPtr_q[PW-1:0]] <= inData;
			wrPtr_q              <= wrPtr_q + 1'b1;
		end
	end

	// Read side
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			rdPtr_q <= '0;
		end else if (clkEn && outValid && outReady) begin
			rdPtr_q <= rdPtr_q + 1'b1;
		end
	end
endmodule // sfci_fifo

module sfci_flash_front (
	input  wire logic                   ref_clk,
	input  wire logic                   rstn,
	input  wire logic                   clkEn,
	input  wire logic                   sckPin,
	input  wire logic                   csPinN,
	input  wire logic                   serialInLane0Din,
	output logic                        serialInLane0Dout,
	output logic                        serialInLane0Oe,
	input  wire logic                   serialOutLane1Din,
	output logic                        serialOutLane1Dout,
	output logic                        serialOutLane1Oe,
	input  wire logic                   writeProtectNLane2Din,
	output logic                        writeProtectNLane2Dout,
	output logic                        writeProtectNLane2Oe,
	input  wire logic                   pauseNLane3Din,
	output logic                        pauseNLane3Dout,
	output logic                        pauseNLane3Oe,
	input  wire logic                   quadEnable,
	output logic                        memRdReq,
	output logic [sfci_pkg::ADDR_W-1:0] memRdAddr,
	input  wire logic [7:0]             memRdData,
	output logic                        memOpStart,
	output sfci_pkg::sfci_mem_req_t     memOp,
	input  wire logic                   memOpDone,
	input  wire logic                   memOpFail,
	output logic                        progValid,
	input  wire logic                   progReady,
	output logic [7:0]                  progClearMask,
	output sfci_pkg::sfci_status_t      statusOut,
	output logic                        activePower,
	output logic                        standby
);
	import sfci_pkg::*;

	typedef enum {S_OPC, S_ADDR, S_MODE, S_RD, S_WD, S_SRW, S_SRDN, S_ERW, S_IGN} sfci_state_t;

	logic [PIN_COUNT-1:0] pinRaw;       // Raw pin levels
	logic [PIN_COUNT-1:0] pinF;         // Filtered pin levels
	logic                 sckPrev_q;    // Edge detection history
	logic                 csPrev_q;
	logic                 armed_q;      // Seen a select fall since reset
	sfci_state_t          st_q;         // Frame phase
	sfci_lanes_t          laneW_q;      // Lanes in use this phase
	logic [2:0]           bitCnt_q;     // Bits of current input byte
	logic [7:0]           inSh_q;       // Input shifter
	logic [7:0]           cmd_q;        // Opcode of this frame
	logic [1:0]           byteCnt_q;    // Address byte counter
	logic [ADDR_W-1:0]    addr_q;       // Target address
	logic [8:0]           progCnt_q;    // Program bytes taken
	logic                 ovf_q;        // Program byte was lost
	logic [7:0]           srNew_q;      // Pending status value
	logic                 readStat_q;   // Data phase shows status
	logic [7:0]           outSh_q;      // Output shifter
	logic [2:0]           outCnt_q;     // Bits already sent of byte
	logic [3:0]           outLanes_q;   // Driven lane values
	logic                 outActive_q;  // Drive phase has begun
	logic [7:0]           nextByte_q;   // Prefetched read byte
	logic                 rdPend_q;     // Read answer due this cycle
	logic [ADDR_W-1:0]    rdAddr_q;     // Fetch address
	sfci_status_t         sr_q;         // Status register
	logic [9:0]           srTimer_q;    // Status write time left
	logic                 opSr_q;       // Running op is a status write
	sfci_op_t             runKind_q;    // Program or wipe; every wipe kept as OP_WIPE_BLOCK
	logic                 fifoInReady;  // Room for a program byte

	assign pinRaw = {pauseNLane3Din, writeProtectNLane2Din, serialOutLane1Din,
		serialInLane0Din, csPinN, sckPin};

	// Three-stage synchroniser; a change counts once stages two and three agree
	for (genvar i = 0; i < PIN_COUNT; i++) begin : gSync
		logic [2:0] s_q;
		logic       f_q;
		always_ff @(posedge ref_clk) begin
			if (!rstn) begin
				s_q <= {3{PIN_RST[i]}};
				f_q <= PIN_RST[i];
			end else if (clkEn) begin
				s_q <= {s_q[1:0], pinRaw[i]};
				if (s_q[1] == s_q[2]) begin
					f_q <= s_q[2];
				end
			end
		end
		assign pinF[i] = f_q;
	end

	// Pin roles; quad mode retires protect and pause
	logic       csLow, quadOn, paused, wpLow;
	logic [3:0] laneIn;
	assign csLow  = !pinF[PIN_CS];                                      // RQ20
	assign quadOn = quadEnable;
	assign laneIn = pinF[PIN_LANE0+:4];
	assign paused = csLow && !laneIn[3] && !quadOn;                     // RQ5 RQ22
	assign wpLow  = !laneIn[2] && !quadOn;                              // RQ22

	// Edge finders; pause swallows edges but history still follows
	logic sckRise, sckFall, csFall, csRise;
	assign sckRise = pinF[PIN_SCK] && !sckPrev_q;                       // RQ2 RQ8
	assign sckFall = !pinF[PIN_SCK] && sckPrev_q;                       // RQ1 RQ8
	assign csFall  = csLow && csPrev_q;
	assign csRise  = !csLow && !csPrev_q;

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			sckPrev_q <= 1'b0;
			csPrev_q  <= 1'b1;
			armed_q   <= 1'b0;
		end else if (clkEn) begin
			sckPrev_q <= pinF[PIN_SCK];
			csPrev_q  <= pinF[PIN_CS];
			if (csFall) begin
				armed_q <= 1'b1;                                            // RQ4
			end
		end
	end

	// Lanes per clock and incoming byte assembly, high bits first
	logic [3:0] step, cntD;
	logic [7:0] inByte;
	always_comb begin
		unique case (laneW_q)
			LANE2: begin
				step   = 4'h2;
				inByte = {inSh_q[5:0], laneIn[1:0]};                       // RQ7 RQ23
			end
			LANE4: begin
				step   = 4'h4;
				inByte = {inSh_q[3:0], laneIn};                             // RQ7
			end
			default: begin
				step   = 4'h1;
				inByte = {inSh_q[6:0], laneIn[0]};                          // RQ23
			end
		endcase
		cntD = {1'b0, bitCnt_q} + step;
	end

	// Frame events
	logic act, byteIn, opcIn, allowed, addrDone, prot, pushByte;
	logic startProg, startErase, startSr, lostProg;
	logic [ADDR_W-1:0] newAddr;
	logic [8:0]        protN;
	assign act      = armed_q && csLow && !paused && sckRise;             // RQ4 RQ5 RQ10
	assign byteIn   = act && cntD[3];                                     // RQ10
	assign opcIn    = byteIn && st_q == S_OPC;
	assign allowed  = !sr_q.opPendingBit || inByte == CMD_READ_STATUS;
	assign addrDone = byteIn && st_q == S_ADDR && byteCnt_q == 2'h2;
	assign newAddr  = {addr_q[15:0], inByte};
	assign protN    = (sr_q.protectRangeBits == 3'h7) ? SECTOR_COUNT
		: (sr_q.protectRangeBits == 3'h0) ? 9'h000 : 9'(PROT_UNIT << sr_q.protectRangeBits);
	assign prot     = wpLow && ({1'b0, newAddr[23:16]} >= SECTOR_COUNT - protN);       // RQ6
	assign pushByte = byteIn && st_q == S_WD && progCnt_q < PAGE_BYTES;                // RQ12
	assign startProg  = csRise && st_q == S_WD && bitCnt_q == 3'h0 && progCnt_q != 9'h000 && !ovf_q;
	assign lostProg   = csRise && st_q == S_WD && ovf_q;
	assign startErase = csRise && st_q == S_ERW && bitCnt_q == 3'h0;
	assign startSr    = csRise && st_q == S_SRDN && bitCnt_q == 3'h0 && !(sr_q.srwd && wpLow);

	// Frame sequencer: opcode, address, mode byte, data phases
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			st_q       <= S_IGN;
			laneW_q    <= LANE1;
			bitCnt_q   <= 3'h0;
			inSh_q     <= 8'h00;
			cmd_q      <= 8'h00;
			byteCnt_q  <= 2'h0;
			addr_q     <= '0;
			progCnt_q  <= 9'h000;
			ovf_q      <= 1'b0;
			srNew_q    <= 8'h00;
			readStat_q <= 1'b0;
		end else if (clkEn) begin
			if (csFall) begin
				// Fresh frame; a select held low through reset also gets here, as the select filter resets high
				st_q       <= S_OPC;
				laneW_q    <= LANE1;
				bitCnt_q   <= 3'h0;
				byteCnt_q  <= 2'h0;
				progCnt_q  <= 9'h000;
				ovf_q      <= 1'b0;
				readStat_q <= 1'b0;
			end else if (csRise) begin
				st_q <= S_IGN;                                              // RQ3
			end else if (act && st_q != S_IGN) begin
				inSh_q   <= inByte;
				bitCnt_q <= cntD[2:0];
				if (byteIn) begin
					unique case (st_q)
						S_OPC: begin
							cmd_q <= inByte;
							st_q  <= S_IGN;
							if (allowed) begin
								unique case (inByte)
									CMD_READ_STATUS: begin
										st_q       <= S_RD;
										readStat_q <= 1'b1;                 // RQ18
									end
									CMD_WRITE_STATUS: if (sr_q.writeEnableLatch) st_q <= S_SRW;
									CMD_READ: st_q <= S_ADDR;
									CMD_DUAL_IO_READ: begin
										st_q    <= S_ADDR;
										laneW_q <= LANE2;                   // RQ15
									end
									CMD_QUAD_IO_READ: if (quadOn) begin
										st_q    <= S_ADDR;
										laneW_q <= LANE4;                   // RQ15
									end
									CMD_PAGE_PROGRAM, CMD_BLOCK_WIPE, CMD_SMALL_PARAM_WIPE,
									CMD_MID_PARAM_WIPE: if (sr_q.writeEnableLatch) st_q <= S_ADDR;   // RQ11 RQ17
									CMD_QUAD_PAGE_PROGRAM: if (sr_q.writeEnableLatch && quadOn) st_q <= S_ADDR;  // RQ14
									CMD_FULL_ARRAY_WIPE: begin
										// With write protect low, any protected area blocks the whole-array wipe
										if (sr_q.writeEnableLatch && !(wpLow && protN != 9'h000)) st_q <= S_ERW;  // RQ6
									end
									default: st_q <= S_IGN;
								endcase
							end
						end
						S_ADDR: begin
							addr_q    <= newAddr;
							byteCnt_q <= byteCnt_q + 2'h1;
							if (byteCnt_q == 2'h2) begin
								unique case (cmd_q)
									CMD_READ: st_q <= S_RD;
									CMD_DUAL_IO_READ, CMD_QUAD_IO_READ: st_q <= S_MODE;
									CMD_PAGE_PROGRAM: st_q <= prot ? S_IGN : S_WD;                 // RQ6
									CMD_QUAD_PAGE_PROGRAM: begin
										st_q    <= prot ? S_IGN : S_WD;     // RQ6
										laneW_q <= LANE4;                   // RQ14
									end
									default: st_q <= prot ? S_IGN : S_ERW;  // RQ6
								endcase
							end
						end
						S_MODE: st_q <= S_RD;
						S_WD: begin
							if (pushByte) begin
								progCnt_q <= progCnt_q + 9'h001;            // RQ12
								ovf_q     <= ovf_q || !fifoInReady;
							end
						end
						S_SRW: begin
							srNew_q <= inByte;
							st_q    <= S_SRDN;
						end
						S_ERW, S_SRDN: st_q <= S_IGN;                       // Extra bytes abort
						S_RD: st_q <= S_RD;
						default: st_q <= S_IGN;
					endcase
				end
			end
		end
	end

	// Program bytes travel as clear masks, so a cell can only go 1 to 0
	sfci_fifo #(
		.WIDTH (8),
		.DEPTH (FIFO_DEPTH)
	) uFifo (
		.ref_clk  (ref_clk),
		.rstn     (rstn),
		.clkEn    (clkEn),
		.inValid  (pushByte),
		.inReady  (fifoInReady),
		.inData   (~inByte),                                              // RQ13
		.outValid (progValid),
		.outReady (progReady),
		.outData  (progClearMask)
	);

	// Read fetch and output shifter, advanced on falling clock edges
	logic [7:0] loadByte;
	logic       shiftOut;
	assign loadByte = readStat_q ? sr_q : nextByte_q;
	assign shiftOut = armed_q && csLow && !paused && sckFall && st_q == S_RD;  // RQ1 RQ10

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			outSh_q     <= 8'h00;
			outCnt_q    <= 3'h0;
			outLanes_q  <= 4'h0;
			outActive_q <= 1'b0;
			nextByte_q  <= 8'h00;
			rdPend_q    <= 1'b0;
			rdAddr_q    <= '0;
			memRdReq    <= 1'b0;
		end else if (clkEn) begin
			memRdReq <= 1'b0;
			rdPend_q <= memRdReq;
			if (rdPend_q) begin
				nextByte_q <= memRdData;
			end
			if (csFall || csRise) begin
				outCnt_q    <= 3'h0;
				outActive_q <= 1'b0;
			end else if (addrDone) begin
				rdAddr_q <= newAddr;
				memRdReq <= 1'b1;                                           // RQ15
			end else if (shiftOut) begin
				outActive_q <= 1'b1;
				outCnt_q    <= 3'(outCnt_q + step[2:0]);
				if (outCnt_q == 3'h0) begin
					outLanes_q <= (laneW_q == LANE4) ? loadByte[7:4]
						: (laneW_q == LANE2) ? {2'h0, loadByte[7:6]} : {2'h0, loadByte[7], 1'b0};
					outSh_q    <= loadByte << step;
					if (!readStat_q) begin
						rdAddr_q <= rdAddr_q + 1'b1;
						memRdReq <= 1'b1;
					end
				end else begin
					outLanes_q <= (laneW_q == LANE4) ? outSh_q[7:4]
						: (laneW_q == LANE2) ? {2'h0, outSh_q[7:6]} : {2'h0, outSh_q[7], 1'b0};
					outSh_q    <= outSh_q << step;
				end
			end
		end
	end

	// Lane drivers; single lane data leaves on lane 1
	logic drive;
	assign drive                  = outActive_q && csLow && !paused;        // RQ3 RQ5
	assign memRdAddr              = rdAddr_q;
	assign serialOutLane1Dout     = outLanes_q[1];
	assign serialInLane0Dout      = outLanes_q[0];
	assign writeProtectNLane2Dout = outLanes_q[2];
	assign pauseNLane3Dout        = outLanes_q[3];
	assign serialOutLane1Oe       = drive;                                  // RQ7
	assign serialInLane0Oe        = drive && laneW_q != LANE1;              // RQ7
	assign writeProtectNLane2Oe   = drive && laneW_q == LANE4 && quadOn;    // RQ22
	assign pauseNLane3Oe          = drive && laneW_q == LANE4 && quadOn;    // RQ22

	// Status register, latch and operation tracking
	logic srDone, memDone;
	assign srDone  = opSr_q && sr_q.opPendingBit && srTimer_q == 10'h001;
	assign memDone = !opSr_q && sr_q.opPendingBit && memOpDone;

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			sr_q       <= STATUS_RST;
			srTimer_q  <= 10'h000;
			opSr_q     <= 1'b0;
			runKind_q  <= OP_PROG;
			memOpStart <= 1'b0;
			memOp      <= '0;
		end else if (clkEn) begin
			memOpStart <= 1'b0;
			if (opcIn && allowed && inByte == CMD_WRITE_ENABLE) begin
				sr_q.writeEnableLatch <= 1'b1;
			end else if (opcIn && allowed && inByte == CMD_WRITE_DISABLE) begin
				sr_q.writeEnableLatch <= 1'b0;
			end
			if (startProg || startErase) begin
				memOpStart        <= 1'b1;
				memOp.addr        <= addr_q;
				memOp.count       <= progCnt_q;
				memOp.kind        <= startProg ? OP_PROG                    // RQ12
					: (cmd_q == CMD_FULL_ARRAY_WIPE) ? OP_WIPE_ALL          // RQ16
					: (cmd_q == CMD_SMALL_PARAM_WIPE) ? OP_WIPE_SMALL       // RQ17
					: (cmd_q == CMD_MID_PARAM_WIPE) ? OP_WIPE_MID : OP_WIPE_BLOCK;  // RQ16 RQ17
				runKind_q         <= startProg ? OP_PROG : OP_WIPE_BLOCK;
				opSr_q            <= 1'b0;
				sr_q.opPendingBit <= 1'b1;                                  // RQ18
			end else if (startSr) begin
				opSr_q            <= 1'b1;
				srTimer_q         <= 10'(SR_WRITE_CYC);
				sr_q.opPendingBit <= 1'b1;                                  // RQ18
			end else if (srTimer_q != 10'h000) begin
				srTimer_q <= srTimer_q - 10'h001;
			end
			if (lostProg) begin
				sr_q.progFail <= 1'b1;                                      // RQ19
			end
			if (srDone) begin
				sr_q.opPendingBit     <= 1'b0;
				sr_q.writeEnableLatch <= 1'b0;                              // RQ24
				sr_q.srwd             <= srNew_q[7];
				sr_q.protectRangeBits <= srNew_q[4:2];
			end
			if (memDone) begin
				sr_q.opPendingBit     <= 1'b0;                              // RQ18
				sr_q.writeEnableLatch <= 1'b0;                              // RQ24
				if (runKind_q == OP_PROG) begin
					sr_q.progFail <= memOpFail;                             // RQ19
				end else begin
					sr_q.eraseFail <= memOpFail;                            // RQ19
				end
			end
		end
	end

	// Power state follows select and any running operation
	assign statusOut   = sr_q;
	assign activePower = csLow || sr_q.opPendingBit;                        // RQ20 RQ21
	assign standby     = !activePower;                                      // RQ21
endmodule // sfci_flash_front

// *** shared/sfci_pkg.sv ***
/*
 * Shared constants and carriers for the serial flash command front end:
 * opcodes, status byte layout, page and protection figures, timing counts.
 * Assumes a 25 MHz core clock and a memory back end that owns the cells.
 */
package sfci_pkg;

	// Core clock and internal status-write time
	localparam int CLK_PERIOD_NS = 40;
	localparam int SR_WRITE_NS   = 1000;
	localparam int SR_WRITE_CYC  = (SR_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Input synchroniser and pin vector layout
	localparam int PIN_COUNT  = 6;
	localparam int PIN_SCK    = 0;
	localparam int PIN_CS     = 1;
	localparam int PIN_LANE0  = 2;
	localparam logic [5:0] PIN_RST = 6'h02;

	// Geometry
	localparam int ADDR_W          = 24;
	localparam int FIFO_DEPTH      = 4;
	localparam logic [8:0] PAGE_BYTES   = 9'h100;
	localparam logic [8:0] SECTOR_COUNT = 9'h100;
	localparam logic [8:0] PROT_UNIT    = 9'h002;

	// Opcodes, most significant bit first on the wire
	localparam logic [7:0] CMD_WRITE_ENABLE      = 8'h06;
	localparam logic [7:0] CMD_WRITE_DISABLE     = 8'h04;
	localparam logic [7:0] CMD_READ_STATUS       = 8'h05;
	localparam logic [7:0] CMD_WRITE_STATUS      = 8'h01;
	localparam logic [7:0] CMD_READ              = 8'h03;
	localparam logic [7:0] CMD_DUAL_IO_READ      = 8'hBB;
	localparam logic [7:0] CMD_QUAD_IO_READ      = 8'hEB;
	localparam logic [7:0] CMD_PAGE_PROGRAM      = 8'h02;
	localparam logic [7:0] CMD_QUAD_PAGE_PROGRAM = 8'h32;
	localparam logic [7:0] CMD_BLOCK_WIPE        = 8'hD8;
	localparam logic [7:0] CMD_SMALL_PARAM_WIPE  = 8'h20;
	localparam logic [7:0] CMD_MID_PARAM_WIPE    = 8'h40;
	localparam logic [7:0] CMD_FULL_ARRAY_WIPE   = 8'hC7;

	// Lane width of the current phase
	typedef enum logic [1:0] {LANE1, LANE2, LANE4} sfci_lanes_t;

	// Operation handed to the memory back end
	typedef enum logic [2:0] {OP_PROG, OP_WIPE_BLOCK, OP_WIPE_SMALL, OP_WIPE_MID, OP_WIPE_ALL} sfci_op_t;

	typedef struct packed {
		sfci_op_t          kind;
		logic [ADDR_W-1:0] addr;
		logic [8:0]        count;
	} sfci_mem_req_t;

	// Status byte, bit 7 down to bit 0
	typedef struct packed {
		logic       srwd;
		logic       progFail;
		logic       eraseFail;
		logic [2:0] protectRangeBits;
		logic       writeEnableLatch;
		logic       opPendingBit;
	} sfci_status_t;

	localparam sfci_status_t STATUS_RST = 8'h00;

endpackage

// *** dv/sfci_front_checker.sv ***
/* Pin and memory-side checks for the flash front end.
   Assumes a bind onto sfci_flash_front; sees its ports only. */
`timescale 1ns/1ps
module sfci_front_checker (
	input wire logic                    ref_clk,
	input wire logic                    rstn,
	input wire logic                    csPinN,
	input wire logic                    serialInLane0Oe,
	input wire logic                    serialOutLane1Oe,
	input wire logic                    memOpStart,
	input wire sfci_pkg::sfci_mem_req_t memOp,
	input wire logic                    memOpDone,
	input wire sfci_pkg::sfci_status_t  statusOut,
	input wire logic                    activePower,
	input wire logic                    standby
);
	import sfci_pkg::*;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	// Raw select held long enough to clear the filters
	sequence deselHeld; csPinN[*8]; endsequence
	sequence selHeld; (!csPinN)[*6]; endsequence
	// Completion while an operation runs
	sequence doneRun; memOpDone && statusOut.opPendingBit; endsequence
	chk_desel_tristate: assert property (deselHeld |-> !serialOutLane1Oe && !serialInLane0Oe)
		else $error("lane driven while deselected");
	chk_sel_active: assert property (selHeld |-> activePower)
		else $error("selected but not active");
	chk_standby_inverse: assert property (standby == !activePower)
		else $error("standby and active disagree");
	chk_pend_active: assert property (statusOut.opPendingBit |-> activePower)
		else $error("standby while pending");
	chk_start_pend: assert property (memOpStart |-> ##[0:2] statusOut.opPendingBit)
		else $error("pending not set on start");
	chk_start_desel: assert property ($rose(memOpStart) |-> csPinN)
		else $error("operation started inside frame");
	chk_done_idle: assert property (doneRun |-> ##[1:3] !statusOut.opPendingBit)
		else $error("pending stuck after done");
	chk_done_wel: assert property (doneRun |-> ##[1:3] !statusOut.writeEnableLatch)
		else $error("latch kept after done");
	chk_prog_count: assert property (memOpStart && memOp.kind == OP_PROG |-> memOp.count inside {[1:256]})
		else $error("program count out of range");
endmodule // sfci_front_checker

bind sfci_flash_front sfci_front_checker chk (.ref_clk, .rstn, .csPinN, .serialInLane0Oe,
	.serialOutLane1Oe, .memOpStart, .memOp, .memOpDone, .statusOut, .activePower, .standby);

// *** dv/sfci_host_model.sv ***
/* Host master model on the link, modes 0 and 3, clock parked per mode.
   Assumes the bench calls its tasks; lane1 level comes from the bench. */
`timescale 1ns/1ps
module sfci_host_model (
	output logic     sck,
	output logic     csN,
	output logic     mosi,
	input wire logic miso
);
	logic cpol = 1'b0; // Idle clock level, high in mode 3
	initial begin
		sck = 0;
		csN = 1;
		mosi = 0;
	end
	// One byte MSB first; sample late in the high phase for slack
	task automatic xb(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			if (cpol) sck = 0; // Mode 3 opens each bit with a fall
			mosi = tx[i];
			#160 sck = 1;
			#160 rx[i] = miso;
			if (!cpol) sck = 0;
		end
		mosi = ~tx[0]; // Released line never shows the stale bit
	endtask
	// Change mode only while deselected
	task automatic park(input logic p);
		cpol = p;
		sck = p;
		#327;
	endtask
	// Odd delays keep the link out of phase with the core clock
	task automatic sel(input logic v);
		#327 csN = v;
		#327;
	endtask
endmodule // sfci_host_model

// *** dv/tb_top.sv ***
/* Directed bench: host model on the link, memory back end here.
   Assumes the checker is bound from its own file. */
`timescale 1ns/1ps
`define CHK(a, b) begin checkCount++; if ((a) !== (b)) begin errTotal++; \
	$display("[ERR] %0t got %h want %h", $time, (a), (b)); end end
module tb_top;
	import sfci_pkg::*;
	logic          ref_clk = 0;   // Core clock
	logic          rstn = 0;      // Sync reset
	logic          progReady = 1; // Back end takes bytes
	logic          memOpDone = 0; // Back end completion
	logic          memOpFail = 0; // Back end verdict
	logic          wpN = 1;       // Write protect pin level
	wire logic     sck, csN, mosi, l0Oe, l0Do, l1Oe, l1Do, l2Oe, l2Do, l3Oe, l3Do;
	wire logic     memRdReq, memOpStart, progValid, activePower, standby;
	wire logic [23:0] memRdAddr;
	wire logic [7:0]  progClearMask;
	wire sfci_mem_req_t memOp;
	wire sfci_status_t  statusOut;
	sfci_mem_req_t opCap;         // Last started operation
	logic [7:0]    rx, masks[$];
	int            errTotal, checkCount, starts;
	wire logic     miso = l1Oe ? l1Do : ~l1Do; // Released lane shows the inverse
	sfci_flash_front uut (.ref_clk, .rstn, .clkEn(1'b1), .sckPin(sck), .csPinN(csN),
		.serialInLane0Din(l0Oe ? l0Do : mosi), .serialInLane0Dout(l0Do), .serialInLane0Oe(l0Oe),
		.serialOutLane1Din(miso), .serialOutLane1Dout(l1Do), .serialOutLane1Oe(l1Oe),
		.writeProtectNLane2Din(l2Oe ? l2Do : wpN), .writeProtectNLane2Dout(l2Do), .writeProtectNLane2Oe(l2Oe),
		.pauseNLane3Din(l3Oe ? l3Do : 1'b1), .pauseNLane3Dout(l3Do), .pauseNLane3Oe(l3Oe),
		.quadEnable(1'b0), .memRdReq, .memRdAddr, .memRdData(memRdAddr[7:0] ^ 8'h5A),
		.memOpStart, .memOp, .memOpDone, .memOpFail, .progValid, .progReady, .progClearMask,
		.statusOut, .activePower, .standby);
	sfci_host_model host (.sck, .csN, .mosi, .miso);
	always #20 ref_clk = ~ref_clk;
	// Starts and drained bytes as the back end sees them
	always @(posedge ref_clk) begin
		if (memOpStart === 1'b1) begin
			starts++;
			opCap = memOp;
		end
		if (progValid === 1'b1 && progReady) masks.push_back(progClearMask);
	end
	task automatic summarize();
		if (errTotal == 0 && checkCount > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic frame(input logic [7:0] b[$]);
		host.sel(1'b0);
		foreach (b[i]) host.xb(b[i], rx);
		host.sel(1'b1);
	endtask
	task automatic write_enable_cmd();
		frame({CMD_WRITE_ENABLE});
		`CHK(statusOut.writeEnableLatch, 1'b1)
	endtask
	// Await start, read status once to see pending, then complete from the back end
	task automatic finish_op(input sfci_op_t k, input logic [23:0] a, input logic f);
		for (int n = 0; starts == 0; n++) begin
			if (n == 400) begin
				errTotal++;
				summarize();
			end
			@(negedge ref_clk);
		end
		`CHK(opCap.kind, k)
		if (k != OP_WIPE_ALL) `CHK(opCap.addr, a)
		`CHK(standby, 1'b0)
		frame({CMD_READ_STATUS, 8'h00});
		`CHK(rx[0], 1'b1)
		@(negedge ref_clk);
		memOpFail = f;
		memOpDone = 1;
		@(negedge ref_clk);
		memOpDone = 0;
		repeat (4) @(negedge ref_clk);
		`CHK(statusOut.writeEnableLatch, 1'b0)
		starts = 0;
	endtask
	task automatic s_status();
		write_enable_cmd();
		frame({CMD_READ_STATUS, 8'h00});
		`CHK(rx, 8'h02)
		`CHK(standby, 1'b1)
		frame({CMD_WRITE_DISABLE});
		`CHK(statusOut.writeEnableLatch, 1'b0)
	endtask
	task automatic s_read();
		frame({CMD_READ, 8'h00, 8'h00, 8'h10, 8'h00});
		`CHK(rx, 8'h4A)
	endtask
	task automatic s_mode3();
		host.park(1'b1);
		frame({CMD_READ, 8'h00, 8'h00, 8'h21, 8'h00});
		`CHK(rx, 8'h7B)
		host.park(1'b0);
	endtask
	// Back end stalled, so the buffer fills before draining
	task automatic s_prog();
		write_enable_cmd();
		@(negedge ref_clk);
		progReady = 0;
		frame({CMD_PAGE_PROGRAM, 8'h00, 8'h12, 8'h34, 8'hF0, 8'h3C, 8'hFF, 8'h00});
		`CHK(progValid, 1'b1)
		@(negedge ref_clk);
		progReady = 1;
		finish_op(OP_PROG, 24'h00_1234, 1'b1);
		`CHK(opCap.count, 9'h004)
		`CHK(statusOut.progFail, 1'b1)
		`CHK({masks[0], masks[1], masks[2], masks[3]}, 32'h0FC3_00FF)
	endtask
	// Whole array protected, pin low: program refused, then range cleared
	task automatic s_protect();
		write_enable_cmd();
		frame({CMD_WRITE_STATUS, 8'h1C});
		repeat (40) @(negedge ref_clk);
		`CHK(statusOut.protectRangeBits, 3'h7)
		wpN = 0;
		write_enable_cmd();
		frame({CMD_PAGE_PROGRAM, 8'hFF, 8'h00, 8'h00, 8'h55});
		repeat (8) @(negedge ref_clk);
		`CHK(starts, 0)
		wpN = 1;
		frame({CMD_WRITE_STATUS, 8'h00});
		repeat (40) @(negedge ref_clk);
		`CHK(statusOut.protectRangeBits, 3'h0)
	endtask
	task automatic s_wipes();
		logic [7:0] opc[4] = '{CMD_BLOCK_WIPE, CMD_SMALL_PARAM_WIPE, CMD_MID_PARAM_WIPE, CMD_FULL_ARRAY_WIPE};
		sfci_op_t kd[4] = '{OP_WIPE_BLOCK, OP_WIPE_SMALL, OP_WIPE_MID, OP_WIPE_ALL};
		for (int i = 0; i < 4; i++) begin
			write_enable_cmd();
			if (i < 3) frame({opc[i], 8'h02, 8'h00, 8'h00});
			else frame({opc[i]});
			finish_op(kd[i], 24'h02_0000, i[0]);
			`CHK(statusOut.eraseFail, i[0])
		end
	endtask
	initial begin
		repeat (6) @(negedge ref_clk);
		rstn = 1;
		s_status();
		s_read();
		s_mode3();
		s_prog();
		s_protect();
		s_wipes();
		summarize();
	end
endmodule // tb_top
